//--- ccu_params.svh
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain register port).
// ----------------------------------------------------------------
`define CCU_OFS_CONFIG 8'h04
`define CCU_OFS_PWRSTAT 8'h08
`define CCU_OFS_ACCESS 8'h0C

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define CCU_CFG_SIZE1_LSB 12
`define CCU_CFG_SIZE0_LSB 8
`define CCU_CFG_COH1_BIT 5
`define CCU_CFG_COH0_BIT 4
`define CCU_CFG_NPROC_BIT 0
`define CCU_PS_P1_LSB 8
`define CCU_PS_P0_LSB 0

// ----------------------------------------------------------------
// Encodings and reset values.
// ----------------------------------------------------------------
`define CCU_SIZE_MAX 4'h5
`define CCU_PS_RESET 2'h0
`define CCU_ACC_RESET 2'h3

`endif

//--- ccu_pkg.sv
package ccu_pkg;

	// Two-bit power status of one processor.
	typedef logic [1:0] ccu_pstat_t;

	// Decoded meaning of a power status field.
	typedef enum logic [1:0] {
		CCU_PWR_ON,
		CCU_PWR_DORMANT,
		CCU_PWR_OFF
	} ccu_pmode_e;

endpackage

//--- ccu_pwr_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries the stored status and the per-processor wait state to the output stage.
interface ccu_pwr_if;
	logic [1:0] status0;
	logic [1:0] status1;
	logic [1:0] wait_for_interrupt_state;
	logic [3:0] ctl;
	modport src (output status0, output status1, output wait_for_interrupt_state, input ctl);
	modport dst (input status0, input status1, input wait_for_interrupt_state, output ctl);
endinterface

`default_nettype wire

//--- ccu_pwr_out.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccu_params.svh"

// Drives the power-control bus for both processors.
module ccu_pwr_out (
	input wire logic clk_i,
	input wire logic nrst_i,
	ccu_pwr_if.dst pw
);
	typedef struct packed {
		logic [3:0] ctl;
	} ccu_po_s;

	ccu_po_s st;
	ccu_po_s next_st;

	// Decode a status field: a leading zero keeps power, 10 dormant, 11 off.
	function automatic logic [1:0] ccu_dec(input logic [1:0] s);
		ccu_pkg::ccu_pmode_e m;
		m = ccu_pkg::CCU_PWR_ON;
		if (s[1]) begin // R10
			m = s[0] ? ccu_pkg::CCU_PWR_OFF : ccu_pkg::CCU_PWR_DORMANT;
		end
		return {m == ccu_pkg::CCU_PWR_OFF, m == ccu_pkg::CCU_PWR_DORMANT};
	endfunction

	// The bus is only live while its processor waits; otherwise it asks for nothing.
	always_comb begin
		next_st = st;
		next_st.ctl[1:0] = pw.wait_for_interrupt_state[0] ? ccu_dec(pw.status0) : 2'h0; // R14
		next_st.ctl[3:2] = pw.wait_for_interrupt_state[1] ? ccu_dec(pw.status1) : 2'h0; // R14
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pw.ctl = st.ctl;

	// The bus stays quiet one cycle after its processor leaves the wait state.
	idle_bus_quiet_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R14
		!pw.wait_for_interrupt_state[0] |=> pw.ctl[1:0] == 2'h0)
		else $error("power bus active outside wait state");
	// A status of 11 while waiting asks for power-off on the next cycle.
	off_request_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
		pw.wait_for_interrupt_state[1] && pw.status1 == 2'h3 |=> pw.ctl[3:2] == 2'h2)
		else $error("power-off not requested");
	// A leading zero never yields any request.
	on_keeps_power_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
		!pw.status0[1] |=> pw.ctl[1:0] == 2'h0)
		else $error("powered processor released");
endmodule

`default_nettype wire

//--- ccu_sync2.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for pin-level inputs.
module ccu_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} ccu_sy_s;

	ccu_sy_s st;
	ccu_sy_s next_st;

	// The first stage is read only by the second.
	always_comb begin
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q_o = st.s2;
endmodule

`default_nettype wire

//--- ccu_regs.sv
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "ccu_params.svh"

// Contract
// R1: configuration register ignores all writes
// R2: bits 15:12 give processor one cache size
// R3: bits 11:8 give processor zero cache size
// R4: only size codes zero to five reported
// R5: coherency bit set when symmetric and present
// R6: bit 5 processor one, bit 4 zero
// R7: bit 0 set when two processors present
// R8: status write needs writer's access bit
// R9: status fields at bits 9:8 and 1:0
// R10: 0x on, 10 dormant, 11 off
// R11: status fields steer external power controller
// R12: processor writes status before low power
// R13: processor runs barrier then wait instruction
// R14: power bus enabled only in wait state
// R15: status fields remain readable at all times
// R16: reserved bits read zero, writes ignored
module ccu_regs #(
	parameter logic [3:0] SIZE0 = 4'h4,
	parameter logic [3:0] SIZE1 = 4'h4,
	parameter logic TWO_PROC = 1'b1
) (
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic WR_CPU_I,
	output logic [31:0] RDATA_O,
	input wire logic [1:0] SYMMETRIC_I,
	input wire logic [1:0] WAIT_FOR_INTERRUPT_STATE_I,
	output logic [3:0] POWER_CONTROL_OUT_BUS_O
);
	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef struct packed {
		ccu_pkg::ccu_pstat_t ps0;
		ccu_pkg::ccu_pstat_t ps1;
		logic [1:0] access;
		logic [31:0] rdata;
	} ccu_rg_s;

	ccu_rg_s st;
	ccu_rg_s next_st;
	logic [1:0] sym_sync;
	logic [1:0] wfi_sync;
	logic [31:0] cfg_word;
	logic [31:0] ps_word;
	logic [1:0] present;

	ccu_pwr_if pwr ();

	// ----------------------------------------------------------------
	// Pin synchronisers.
	// ----------------------------------------------------------------
	ccu_sync2 #(.WIDTH(4)) u_sync (
		.clk_i(SYS_CLK_I),
		.nrst_i(NRST_I),
		.d_i({SYMMETRIC_I, WAIT_FOR_INTERRUPT_STATE_I}),
		.q_o({sym_sync, wfi_sync})
	);

	// Clamp a size code: reserved codes would mislead software, so they read as none.
	function automatic logic [3:0] ccu_size(input logic [3:0] c);
		return (c > `CCU_SIZE_MAX) ? 4'h0 : c; // R4
	endfunction

	// ----------------------------------------------------------------
	// Read words.
	// ----------------------------------------------------------------
	// Processor one is absent in a single configuration, so its fields read zero.
	always_comb begin
		present = {TWO_PROC, 1'b1};
		cfg_word = 32'h0; // R16
		cfg_word[`CCU_CFG_SIZE1_LSB +: 4] = TWO_PROC ? ccu_size(SIZE1) : 4'h0; // R2
		cfg_word[`CCU_CFG_SIZE0_LSB +: 4] = ccu_size(SIZE0); // R3
		cfg_word[`CCU_CFG_COH1_BIT] = sym_sync[1] & present[1]; // R5 R6
		cfg_word[`CCU_CFG_COH0_BIT] = sym_sync[0] & present[0]; // R5 R6
		cfg_word[`CCU_CFG_NPROC_BIT] = TWO_PROC; // R7
		ps_word = 32'h0; // R16
		ps_word[`CCU_PS_P1_LSB +: 2] = st.ps1; // R9
		ps_word[`CCU_PS_P0_LSB +: 2] = st.ps0; // R9
	end

	// ----------------------------------------------------------------
	// Register port.
	// ----------------------------------------------------------------
	// Status writes are gated per writer; the config offset has no write path.
	always_comb begin
		next_st = st;
		next_st.rdata = 32'h0;
		if (WR_I && ADDR_I == `CCU_OFS_PWRSTAT && st.access[WR_CPU_I]) begin // R8
			next_st.ps0 = WDATA_I[`CCU_PS_P0_LSB +: 2]; // R9
			if (TWO_PROC) begin
				next_st.ps1 = WDATA_I[`CCU_PS_P1_LSB +: 2]; // R9
			end
		end
		if (WR_I && ADDR_I == `CCU_OFS_ACCESS) begin
			next_st.access = WDATA_I[1:0];
		end
		if (RD_I) begin
			unique case (ADDR_I)
				`CCU_OFS_CONFIG: next_st.rdata = cfg_word; // R1
				`CCU_OFS_PWRSTAT: next_st.rdata = ps_word; // R15
				`CCU_OFS_ACCESS: next_st.rdata = {30'h0, st.access};
				default: next_st.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I) begin
			st.ps0 <= `CCU_PS_RESET;
			st.ps1 <= `CCU_PS_RESET;
			st.access <= `CCU_ACC_RESET;
			st.rdata <= 32'h0;
		end else begin
			st <= next_st;
		end
	end

	assign RDATA_O = st.rdata;

	// ----------------------------------------------------------------
	// Power-control output.
	// ----------------------------------------------------------------
	// The stored fields are what the external controller acts on.
	assign pwr.status0 = st.ps0; // R11
	assign pwr.status1 = st.ps1; // R11
	assign pwr.wait_for_interrupt_state = wfi_sync & present;

	ccu_pwr_out u_out (
		.clk_i(SYS_CLK_I),
		.nrst_i(NRST_I),
		.pw(pwr.dst)
	);

	assign POWER_CONTROL_OUT_BUS_O = pwr.ctl;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	sequence ccu_ps_write_ok;
		WR_I && ADDR_I == `CCU_OFS_PWRSTAT && st.access[WR_CPU_I];
	endsequence

	sequence ccu_ps_read;
		RD_I && ADDR_I == `CCU_OFS_PWRSTAT;
	endsequence

	sequence ccu_cfg_read;
		RD_I && ADDR_I == `CCU_OFS_CONFIG;
	endsequence

	sequence ccu_acc_write;
		WR_I && ADDR_I == `CCU_OFS_ACCESS;
	endsequence

	cfg_read_only_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R1
		ccu_cfg_read |=> RDATA_O == $past(cfg_word))
		else $error("config read mismatch");
	size1_field_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R2
		ccu_cfg_read |=> RDATA_O[15:12] <= 4'h5)
		else $error("processor one size reserved");
	size0_field_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R3
		ccu_cfg_read |=> RDATA_O[11:8] == ccu_size(SIZE0))
		else $error("processor zero size wrong");
	size_code_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R4
		cfg_word[11:8] <= 4'h5 && cfg_word[15:12] <= 4'h5)
		else $error("reserved size code reported");
	coh_bits_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R5
		ccu_cfg_read
		|=> RDATA_O[5:4] == ($past(sym_sync) & present))
		else $error("coherency bits wrong");
	coh_order_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R6
		ccu_cfg_read |=> RDATA_O[5] == $past(sym_sync[1] & TWO_PROC)
		&& RDATA_O[4] == $past(sym_sync[0]))
		else $error("coherency bits swapped");
	nproc_bit_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R7
		cfg_word[0] == TWO_PROC)
		else $error("processor count wrong");
	ps_gated_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R8
		WR_I && ADDR_I == `CCU_OFS_PWRSTAT && !st.access[WR_CPU_I]
		|=> $stable(st.ps0) && $stable(st.ps1))
		else $error("gated status write took effect");
	ps_write_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R9 R15
		ccu_ps_write_ok ##1 (ccu_ps_read and !WR_I)
		|=> RDATA_O[1:0] == $past(WDATA_I[1:0], 2))
		else $error("status readback wrong");
	reserved_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R16
		ccu_ps_read |=> RDATA_O[31:10] == 22'h0 && RDATA_O[7:2] == 6'h0)
		else $error("reserved status bits set");
	bus_two_cycle_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R11 R14
		pwr.wait_for_interrupt_state[0] && st.ps0 == 2'h2 ##1 $stable(st.ps0) && pwr.wait_for_interrupt_state[0]
		|=> POWER_CONTROL_OUT_BUS_O[1:0] == 2'h1)
		else $error("dormant not signalled");

	// ----------------------------------------------------------------
	// Configuration checks.
	// ----------------------------------------------------------------
	// The upper reserved field reads zero.
	cfg_reserved_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R16
		ccu_cfg_read |=> RDATA_O[31:16] == 16'h0)
		else $error("config upper reserved bits set");
	// The two small reserved fields read zero as well.
	cfg_low_reserved_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R16
		ccu_cfg_read |=> RDATA_O[7:6] == 2'h0 && RDATA_O[3:1] == 3'h0)
		else $error("config lower reserved bits set");
	// The assembled word never carries a reserved bit, read or not.
	cfg_word_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R16
		cfg_word[31:16] == 16'h0 && cfg_word[7:6] == 2'h0 && cfg_word[3:1] == 3'h0)
		else $error("config word reserved bits set");
	// A write aimed at the configuration offset touches no stored state.
	cfg_write_ignored_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R1
		WR_I && ADDR_I == `CCU_OFS_CONFIG
		|=> $stable(st.ps0) && $stable(st.ps1) && $stable(st.access))
		else $error("config write changed state");
	// Only the mode pins may move the configuration word.
	cfg_follows_pins_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R1
		$stable(sym_sync) |-> $stable(cfg_word))
		else $error("config word moved without pins");
	// A lone processor shows no size for the missing one.
	size1_absent_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R2
		TWO_PROC || cfg_word[15:12] == 4'h0)
		else $error("absent processor shows a size");
	// The read returns the processor one size field unchanged.
	size1_value_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R2
		ccu_cfg_read |=> RDATA_O[15:12] == $past(cfg_word[15:12]))
		else $error("processor one size read wrong");
	// The processor zero field always holds the clamped size.
	size0_value_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R3
		cfg_word[11:8] == ccu_size(SIZE0))
		else $error("processor zero size field wrong");
	// Bit five follows processor one's mode pin, and only if it exists.
	coh1_pin_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R5 R6
		cfg_word[5] == (sym_sync[1] & TWO_PROC))
		else $error("processor one coherency bit wrong");
	// Bit four follows processor zero's mode pin.
	coh0_pin_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R5 R6
		cfg_word[4] == sym_sync[0])
		else $error("processor zero coherency bit wrong");
	// The read returns the coherency field of the word it sampled.
	coh_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R6
		ccu_cfg_read |=> RDATA_O[5:4] == $past(cfg_word[5:4]))
		else $error("coherency field read wrong");
	// The count bit reads back as configured.
	nproc_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R7
		ccu_cfg_read |=> RDATA_O[0] == TWO_PROC)
		else $error("processor count read wrong");

	// ----------------------------------------------------------------
	// Status and access checks.
	// ----------------------------------------------------------------
	// An accepted write lands in processor zero's field.
	ps_write_p0_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R8 R9
		ccu_ps_write_ok |=> st.ps0 == $past(WDATA_I[1:0]))
		else $error("processor zero status not written");
	// An accepted write lands in processor one's field when it exists.
	ps_write_p1_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R8 R9
		ccu_ps_write_ok |=> st.ps1 == (TWO_PROC ? $past(WDATA_I[9:8]) : 2'h0))
		else $error("processor one status not written");
	// Without a write the stored status holds, so a waking processor can read it.
	ps_no_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R15
		!WR_I |=> $stable(st.ps0) && $stable(st.ps1))
		else $error("status changed without a write");
	// Writes to other offsets leave the status alone.
	ps_other_addr_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R9
		WR_I && ADDR_I != `CCU_OFS_PWRSTAT |=> $stable(st.ps0) && $stable(st.ps1))
		else $error("status changed by another offset");
	// The read returns both stored fields in their places.
	ps_read_value_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R9 R15
		ccu_ps_read |=> RDATA_O[9:8] == $past(st.ps1) && RDATA_O[1:0] == $past(st.ps0))
		else $error("status fields read wrong");
	// The assembled status word never carries a reserved bit.
	ps_high_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R16
		ps_word[31:10] == 22'h0 && ps_word[7:2] == 6'h0)
		else $error("status word reserved bits set");
	// A missing processor keeps a status of must stay powered.
	ps1_absent_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R9
		TWO_PROC || st.ps1 == 2'h0)
		else $error("absent processor has a status");
	// A write to the access offset loads both access bits from the data.
	acc_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R8
		ccu_acc_write |=> st.access == $past(WDATA_I[1:0]))
		else $error("access bits not written");
	// The access bits change only by their own write.
	acc_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R8
		!(WR_I && ADDR_I == `CCU_OFS_ACCESS) |=> $stable(st.access))
		else $error("access bits changed");
	// The access bits read back in the low two bits.
	acc_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R8
		RD_I && ADDR_I == `CCU_OFS_ACCESS |=> RDATA_O == {30'h0, $past(st.access)})
		else $error("access bits read wrong");
	// Read data stand one cycle only; otherwise the port shows zero.
	rdata_idle_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R16
		!RD_I |=> RDATA_O == 32'h0)
		else $error("read data outside a read");
	// An unmapped offset reads zero.
	rdata_unmapped_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R16
		RD_I && ADDR_I != `CCU_OFS_CONFIG && ADDR_I != `CCU_OFS_PWRSTAT
		&& ADDR_I != `CCU_OFS_ACCESS |=> RDATA_O == 32'h0)
		else $error("unmapped read not zero");

	// ----------------------------------------------------------------
	// Power bus checks.
	// ----------------------------------------------------------------
	// A missing processor never reports a wait state to the output stage.
	wfi_present_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R14
		!pwr.wait_for_interrupt_state[1] || TWO_PROC)
		else $error("absent processor waiting");
	// The output stage sees exactly the stored fields.
	status_to_ctl_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R11
		pwr.status0 == st.ps0 && pwr.status1 == st.ps1)
		else $error("output stage sees stale status");
	// Processor one's half of the bus is quiet outside its wait state.
	bus_quiet_p1_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R14
		!pwr.wait_for_interrupt_state[1] |=> POWER_CONTROL_OUT_BUS_O[3:2] == 2'h0)
		else $error("processor one bus active outside wait");
	// Processor zero's half of the bus is quiet outside its wait state.
	bus_quiet_p0_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R14
		!pwr.wait_for_interrupt_state[0] |=> POWER_CONTROL_OUT_BUS_O[1:0] == 2'h0)
		else $error("processor zero bus active outside wait");
	// Dormant and off are never asked for at once for one processor.
	bus_one_hot_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R10
		POWER_CONTROL_OUT_BUS_O[1:0] != 2'h3 && POWER_CONTROL_OUT_BUS_O[3:2] != 2'h3)
		else $error("dormant and off requested together");
	// Processor one waiting with status 11 asks for power-off.
	bus_p1_off_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R10 R11
		pwr.wait_for_interrupt_state[1] && st.ps1 == 2'h3 |=> POWER_CONTROL_OUT_BUS_O[3:2] == 2'h2)
		else $error("processor one off not requested");
	// Processor zero waiting with status 11 asks for power-off.
	bus_p0_off_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R10 R11
		pwr.wait_for_interrupt_state[0] && st.ps0 == 2'h3 |=> POWER_CONTROL_OUT_BUS_O[1:0] == 2'h2)
		else $error("processor zero off not requested");
	// Processor one waiting with status 10 asks for dormant mode.
	bus_p1_dormant_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R10
		pwr.wait_for_interrupt_state[1] && st.ps1 == 2'h2 |=> POWER_CONTROL_OUT_BUS_O[3:2] == 2'h1)
		else $error("processor one dormant not requested");
	// A leading zero keeps processor one powered whatever its pin does.
	bus_p1_on_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R10
		!st.ps1[1] |=> POWER_CONTROL_OUT_BUS_O[3:2] == 2'h0)
		else $error("powered processor one released");
endmodule

`default_nettype wire

//--- ccu_pwr_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Processor pins and external power controller.
// ----------------------------------------------------------------
module ccu_pwr_ctl_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [1:0] halt_req_i,
	input wire logic [3:0] pwr_bus_i,
	output logic [1:0] wfi_o,
	output logic [3:0] removed_o
);
	// A processor enters its wait state only when the bench asks, after its status write.
	// The controller latches which domains the bus lets it remove; it acts one cycle late.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wfi_o <= 2'h0;
			removed_o <= 4'h0;
		end else begin
			wfi_o <= halt_req_i;
			removed_o <= pwr_bus_i;
		end
	end
endmodule

`default_nettype wire

//--- coherency_config_power_status_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccu_params.svh"

module coherency_config_power_status_test;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic wr_cpu = 1'b0;
	logic [1:0] sym = 2'h2;
	logic [1:0] halt = 2'h0;
	logic [1:0] wait_for_interrupt_state;
	logic [3:0] bus;
	logic [3:0] removed;
	logic [31:0] rdata;
	logic [31:0] got;
	int error_cnt = 0;
	int tests_run = 0;

	// Odd sizes on the two processors catch swapped fields.
	ccu_regs #(.SIZE0(4'h3), .SIZE1(4'h5), .TWO_PROC(1'b1)) dut_u (
		.SYS_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .WR_CPU_I(wr_cpu), .RDATA_O(rdata), .SYMMETRIC_I(sym),
		.WAIT_FOR_INTERRUPT_STATE_I(wait_for_interrupt_state), .POWER_CONTROL_OUT_BUS_O(bus));

	ccu_pwr_ctl_model partner_u (.clk_i(clk), .nrst_i(nrst), .halt_req_i(halt),
		.pwr_bus_i(bus), .wfi_o(wait_for_interrupt_state), .removed_o(removed));

	// Clock of 200 MHz.
	always #2.5 clk = ~clk;

	// ----------------------------------------------------------------
	// Bus tasks and comparison.
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic cpu);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_cpu <= cpu;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// A write and a read of one offset on consecutive edges, with no gap between strobes.
	task automatic reg_wr_rd(input logic [7:0] a, input logic [31:0] wd, input logic cpu,
		output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= wd;
		wr_cpu <= cpu;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic t_config;
		reg_rd(`CCU_OFS_CONFIG, got);
		chk("config", got, 32'h00005321);
		reg_wr(`CCU_OFS_CONFIG, 32'hFFFFFFFF, 1'b0);
		reg_rd(`CCU_OFS_CONFIG, got);
		chk("config after write", got, 32'h00005321);
		reg_rd(8'h10, got);
		chk("unmapped", got, 32'h0);
		// Flip the mode pins so that a hard-wired coherency field shows up.
		@(posedge clk);
		sym <= 2'h1;
		repeat (3) @(posedge clk);
		reg_rd(`CCU_OFS_CONFIG, got);
		chk("config with processor zero coherent", got, 32'h00005311);
	endtask

	task automatic t_status;
		reg_rd(`CCU_OFS_PWRSTAT, got);
		chk("status reset", got, 32'h0);
		reg_wr(`CCU_OFS_PWRSTAT, 32'hFFFFFFFF, 1'b0);
		reg_rd(`CCU_OFS_PWRSTAT, got);
		chk("status fields", got, 32'h00000303);
	endtask

	// Only processor one may write while processor zero's access bit is clear.
	task automatic t_access;
		reg_wr(`CCU_OFS_ACCESS, 32'h2, 1'b0);
		reg_rd(`CCU_OFS_ACCESS, got);
		chk("access bits", got, 32'h00000002);
		reg_wr(`CCU_OFS_PWRSTAT, 32'h0, 1'b0);
		reg_rd(`CCU_OFS_PWRSTAT, got);
		chk("status blocked", got, 32'h00000303);
		reg_wr_rd(`CCU_OFS_PWRSTAT, 32'h202, 1'b1, got);
		chk("status allowed", got, 32'h00000202);
		reg_wr(`CCU_OFS_ACCESS, 32'h3, 1'b1);
	endtask

	// The bus stays quiet until the wait pins rise; pins take two sync stages plus a register.
	task automatic t_bus;
		reg_wr(`CCU_OFS_PWRSTAT, 32'h302, 1'b0);
		repeat (6) @(posedge clk);
		chk("bus without wait", {28'h0, bus}, 32'h0);
		halt <= 2'h3;
		repeat (6) @(posedge clk);
		chk("bus in wait", {28'h0, bus}, 32'h9);
		chk("controller view", {28'h0, removed}, 32'h9);
		for (int c = 0; c < 4; c++) begin
			reg_wr(`CCU_OFS_PWRSTAT, c, 1'b0);
			repeat (4) @(posedge clk);
			chk("bus per code", {28'h0, bus}, {30'h0, c == 3, c == 2});
		end
		halt <= 2'h0;
		repeat (6) @(posedge clk);
		chk("bus after wake", {28'h0, bus}, 32'h0);
		reg_rd(`CCU_OFS_PWRSTAT, got);
		chk("status after wake", got, 32'h00000003);
	endtask

	// ----------------------------------------------------------------
	// Closing and main sequence.
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Reset is held for five cycles, then the pins get time to pass the synchronisers.
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_config();
		t_status();
		t_access();
		t_bus();
		end_of_test();
	end

	// The whole run needs under a hundred cycles; this cuts a hang short.
	initial begin
		#10000;
		error_cnt++;
		end_of_test();
	end
endmodule

`default_nettype wire
